// [verilog/bfp_pkg.sv]
// shared constants for the bridge fault protection block
package bfp_pkg;
  localparam int          BFP_PHASES       = 3;
  localparam int          BFP_ADC_W        = 12;
  localparam logic [11:0] BFP_ADC_MID      = 12'h800;
  localparam int          BFP_BLANK_W      = 8;
  localparam int          BFP_FILT_W       = 4;
  localparam int          BFP_LVL_W        = 4;
  // shutdown level select codes
  localparam logic [1:0]  BFP_OT_136       = 2'h0;
  localparam logic [1:0]  BFP_OT_143       = 2'h1;
  localparam logic [1:0]  BFP_OT_150       = 2'h2;
  // retry bounds
  localparam logic [1:0]  BFP_RETRY_MIN    = 2'h1;
  localparam logic [1:0]  BFP_RETRY_MAX    = 2'h3;
  // brake chopper pwm
  localparam int          BFP_CHOP_W       = 8;
  localparam logic [7:0]  BFP_CHOP_STEP    = 8'h01;
  // short protection config register field positions
  localparam int          BFP_CFG_W        = 24;
  localparam int          BFP_CFG_LS_LVL   = 0;
  localparam int          BFP_CFG_HS_LVL   = 4;
  localparam int          BFP_CFG_FILT     = 8;
  localparam int          BFP_CFG_BLANK    = 12;
  localparam int          BFP_CFG_RETRY    = 20;
  localparam int          BFP_CFG_DIS_VS   = 22;
  localparam int          BFP_CFG_DIS_GND  = 23;
  localparam logic [23:0] BFP_CFG_RESET    = 24'h14_0f_88;
endpackage : bfp_pkg

// [verilog/bfp_short_det.sv]
// per half-bridge short detector: blanking, spike filter, level compare
`timescale 1ns/1ns
module bfp_short_det
  import bfp_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // switching and comparators (already synchronised)
  input  wire logic                   sw_event,
  input  wire logic [BFP_LVL_W-1:0]   hs_drop,
  input  wire logic [BFP_LVL_W-1:0]   ls_drop,
  // configuration
  input  wire logic [BFP_LVL_W-1:0]   hs_level,
  input  wire logic [BFP_LVL_W-1:0]   ls_level,
  input  wire logic [BFP_FILT_W-1:0]  filt_len,
  input  wire logic [BFP_BLANK_W-1:0] blank_len,
  // detections, one-cycle pulses
  output logic                        hs_short,
  output logic                        ls_short
);
  logic [BFP_BLANK_W-1:0] blank_ff, nxt_blank;
  logic [BFP_FILT_W-1:0]  hcnt_ff, nxt_hcnt, lcnt_ff, nxt_lcnt;
  logic                   hs_ff, nxt_hs, ls_ff, nxt_ls;
  logic                   hs_raw, ls_raw;

  always_comb
  begin
    hs_raw = (hs_drop >= hs_level); // RULE_09
    ls_raw = (ls_drop >= ls_level); // RULE_08
    nxt_blank = blank_ff;
    if (sw_event)
      nxt_blank = blank_len; // RULE_05
    else if (blank_ff != '0)
      nxt_blank = blank_ff - 1'b1;
    nxt_hcnt = '0;
    nxt_lcnt = '0;
    nxt_hs   = 1'b0;
    nxt_ls   = 1'b0;
    // blanked comparators are ignored and filters restart
    if (blank_ff == '0 && !sw_event)
    begin
      // a glitch shorter than filt_len cycles never reaches the count
      if (hs_raw)
        nxt_hcnt = (hcnt_ff == filt_len) ? hcnt_ff : hcnt_ff + 1'b1; // RULE_06
      if (ls_raw)
        nxt_lcnt = (lcnt_ff == filt_len) ? lcnt_ff : lcnt_ff + 1'b1; // RULE_06
      nxt_hs = hs_raw && (hcnt_ff + 1'b1 == filt_len); // RULE_04
      nxt_ls = ls_raw && (lcnt_ff + 1'b1 == filt_len); // RULE_04
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      blank_ff <= '0;
      hcnt_ff  <= '0;
      lcnt_ff  <= '0;
      hs_ff    <= 1'b0;
      ls_ff    <= 1'b0;
    end
    else
    begin
      blank_ff <= nxt_blank;
      hcnt_ff  <= nxt_hcnt;
      lcnt_ff  <= nxt_lcnt;
      hs_ff    <= nxt_hs;
      ls_ff    <= nxt_ls;
    end
  end

  assign hs_short = hs_ff;
  assign ls_short = ls_ff;
endmodule : bfp_short_det

// [verilog/bfp_bridge_fault_protection.sv]
// bridge fault protection top: thermal, short retry, brake chopper, adc
// How it works
// RULE_01 - pre-warning flag when sensor crosses pre-warning level
// RULE_02 - selectable shutdown level sets overtemp shutdown flag
// RULE_03 - drivers held off until below pre-warning
// RULE_04 - detect shorts on high and low side
// RULE_05 - ignore detectors for programmable delay after switching
// RULE_06 - spike filter rejects short glitches
// RULE_07 - retry one to three times, then latch off
// RULE_08 - low-side drop compared against its level
// RULE_09 - high-side drop compared against its own level
// RULE_10 - disable short-to-supply ignores low-side events
// RULE_11 - disable short-to-ground ignores high-side events
// RULE_12 - option: per half bridge or global shutdown
// RULE_13 - short settings held in writable internal register
// RULE_14 - brake chopper duty adapts to supply overshoot
// RULE_15 - signed current is adc code minus midpoint
// RULE_16 - sticky status flags for each protection event
`timescale 1ns/1ns
module bfp_bridge_fault_protection
  import bfp_pkg::*;
(
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              srst,
  // temperature sensor comparators (pins)
  input  wire logic                              temp_pw_pin,
  input  wire logic                              temp_136_pin,
  input  wire logic                              temp_143_pin,
  input  wire logic                              temp_150_pin,
  input  wire logic [1:0]                        ot_level_sel,
  // bridge switching and short detector drops (pins)
  input  wire logic [BFP_PHASES-1:0]             sw_event_pin,
  input  wire logic [BFP_PHASES*BFP_LVL_W-1:0]   hs_drop_pin,
  input  wire logic [BFP_PHASES*BFP_LVL_W-1:0]   ls_drop_pin,
  // short protection config register write port
  input  wire logic                              cfg_wr,
  input  wire logic [BFP_CFG_W-1:0]              cfg_wdata,
  input  wire logic                              global_off,
  output logic      [BFP_CFG_W-1:0]              cfg_rdata,
  // status flags and clear
  input  wire logic                              status_clr,
  output logic                                   prewarn_flag,
  output logic                                   overtemp_shutdown_flag,
  output logic      [BFP_PHASES-1:0]             hs_short_flag,
  output logic      [BFP_PHASES-1:0]             ls_short_flag,
  output logic                                   motor_latched_off,
  // gate drive enables
  input  wire logic [BFP_PHASES-1:0]             drive_req,
  output logic      [BFP_PHASES-1:0]             drive_en,
  // brake chopper
  input  wire logic                              overshoot_pin,
  output logic                                   brake_chop,
  // current sense
  input  wire logic [BFP_ADC_W-1:0]              adc_code,
  input  wire logic [1:0]                        adc_phase,
  input  wire logic                              adc_valid,
  output logic signed [BFP_ADC_W-1:0]            phase_current,
  output logic      [1:0]                        phase_current_idx,
  output logic                                   phase_current_valid
);
  localparam int NSYNC = 4 + 1 + BFP_PHASES * (1 + 2 * BFP_LVL_W);
  localparam int NS_ALL = NSYNC;

  // two-stage synchroniser on every pin input
  logic [NS_ALL-1:0] sync1_ff, sync2_ff;
  logic [NS_ALL-1:0] pins;
  assign pins = {temp_pw_pin, temp_136_pin, temp_143_pin, temp_150_pin,
                 overshoot_pin, sw_event_pin, hs_drop_pin, ls_drop_pin};

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  logic                              t_pw, t_136, t_143, t_150, t_over;
  logic [BFP_PHASES-1:0]             t_sw;
  logic [BFP_PHASES*BFP_LVL_W-1:0]   t_hs, t_ls;
  assign {t_pw, t_136, t_143, t_150, t_over, t_sw, t_hs, t_ls} = sync2_ff;

  // configuration register
  logic [BFP_CFG_W-1:0] cfg_ff, nxt_cfg;
  logic [1:0]           retry_w;

  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (cfg_wr)
    begin
      nxt_cfg = cfg_wdata; // RULE_13
      // retry count clamps into one to three
      if (cfg_wdata[BFP_CFG_RETRY +: 2] < BFP_RETRY_MIN)
        nxt_cfg[BFP_CFG_RETRY +: 2] = BFP_RETRY_MIN; // RULE_07
    end
  end

  assign retry_w   = cfg_ff[BFP_CFG_RETRY +: 2];
  assign cfg_rdata = cfg_ff;

  // per phase short detectors
  logic [BFP_PHASES-1:0] hs_det, ls_det;
  for (genvar p = 0; p < BFP_PHASES; p++)
  begin : g_det
    bfp_short_det u_det (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .sw_event  (t_sw[p]),
      .hs_drop   (t_hs[p*BFP_LVL_W +: BFP_LVL_W]),
      .ls_drop   (t_ls[p*BFP_LVL_W +: BFP_LVL_W]),
      .hs_level  (cfg_ff[BFP_CFG_HS_LVL +: BFP_LVL_W]),
      .ls_level  (cfg_ff[BFP_CFG_LS_LVL +: BFP_LVL_W]),
      .filt_len  (cfg_ff[BFP_CFG_FILT +: BFP_FILT_W]),
      .blank_len (cfg_ff[BFP_CFG_BLANK +: BFP_BLANK_W]),
      .hs_short  (hs_det[p]),
      .ls_short  (ls_det[p])
    );
  end

  // thermal, short and retry state
  logic                  pw_ff, nxt_pw, ot_ff, nxt_ot, othold_ff, nxt_othold;
  logic [BFP_PHASES-1:0] hsf_ff, nxt_hsf, lsf_ff, nxt_lsf;
  logic [BFP_PHASES-1:0] off_ff, nxt_off;
  logic [1:0]            retries_ff, nxt_retries;
  logic                  latch_ff, nxt_latch;
  logic                  ot_hit;
  logic [BFP_PHASES-1:0] trip;

  always_comb
  begin
    case (ot_level_sel)
      BFP_OT_136: ot_hit = t_136;
      BFP_OT_143: ot_hit = t_143;
      BFP_OT_150: ot_hit = t_150;
      default:    ot_hit = t_150;
    endcase
    // disabled protections keep their flag but never trip the bridge
    trip = (hs_det & {BFP_PHASES{~cfg_ff[BFP_CFG_DIS_GND]}}) // RULE_11
         | (ls_det & {BFP_PHASES{~cfg_ff[BFP_CFG_DIS_VS]}}); // RULE_10
    nxt_pw  = t_pw | (pw_ff & ~status_clr); // RULE_01
    nxt_ot  = ot_hit | (ot_ff & ~status_clr); // RULE_02
    nxt_hsf = hs_det | (hsf_ff & ~{BFP_PHASES{status_clr}}); // RULE_16
    nxt_lsf = ls_det | (lsf_ff & ~{BFP_PHASES{status_clr}}); // RULE_16
    // hold survives flag clears; only cooling below pre-warning releases
    nxt_othold = ot_hit | (othold_ff & t_pw); // RULE_03
    nxt_off     = off_ff;
    nxt_retries = retries_ff;
    nxt_latch   = latch_ff;
    if (|trip)
    begin
      if (global_off)
        nxt_off = {BFP_PHASES{1'b1}}; // RULE_12
      else
        nxt_off = off_ff | trip; // RULE_12
      if (retries_ff >= retry_w)
        nxt_latch = 1'b1; // RULE_07
      else
        nxt_retries = retries_ff + 1'b1; // RULE_07
    end
    else if (!latch_ff)
    begin
      // a retry re-arms the bridge once the driver drops its request
      nxt_off = off_ff & drive_req;
    end
    if (status_clr && !(|trip))
    begin
      nxt_latch   = 1'b0;
      nxt_retries = 2'h0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cfg_ff     <= BFP_CFG_RESET;
      pw_ff      <= 1'b0;
      ot_ff      <= 1'b0;
      othold_ff  <= 1'b0;
      hsf_ff     <= '0;
      lsf_ff     <= '0;
      off_ff     <= '0;
      retries_ff <= 2'h0;
      latch_ff   <= 1'b0;
    end
    else
    begin
      cfg_ff     <= nxt_cfg;
      pw_ff      <= nxt_pw;
      ot_ff      <= nxt_ot;
      othold_ff  <= nxt_othold;
      hsf_ff     <= nxt_hsf;
      lsf_ff     <= nxt_lsf;
      off_ff     <= nxt_off;
      retries_ff <= nxt_retries;
      latch_ff   <= nxt_latch;
    end
  end

  assign prewarn_flag           = pw_ff;
  assign overtemp_shutdown_flag = ot_ff;
  assign hs_short_flag          = hsf_ff;
  assign ls_short_flag          = lsf_ff;
  assign motor_latched_off      = latch_ff;

  // drive enables registered
  logic [BFP_PHASES-1:0] en_ff, nxt_en;
  always_comb
  begin
    nxt_en = drive_req & ~off_ff & ~trip;
    if (othold_ff || latch_ff)
      nxt_en = '0; // RULE_03
  end

  // brake chopper: duty rises while overshoot seen, decays otherwise
  logic [BFP_CHOP_W-1:0] duty_ff, nxt_duty, pwm_ff, nxt_pwm;
  logic                  chop_ff, nxt_chop;
  always_comb
  begin
    nxt_duty = duty_ff;
    if (t_over && duty_ff != '1)
      nxt_duty = duty_ff + BFP_CHOP_STEP; // RULE_14
    else if (!t_over && duty_ff != '0)
      nxt_duty = duty_ff - BFP_CHOP_STEP; // RULE_14
    nxt_pwm  = pwm_ff + 1'b1;
    nxt_chop = (pwm_ff < duty_ff);
  end

  // adc: signed current from mid-scale
  logic signed [BFP_ADC_W-1:0] cur_ff, nxt_cur;
  logic [1:0]                  idx_ff, nxt_idx;
  logic                        cv_ff, nxt_cv;
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_idx = idx_ff;
    nxt_cv  = adc_valid;
    if (adc_valid)
    begin
      nxt_cur = $signed(adc_code - BFP_ADC_MID); // RULE_15
      nxt_idx = adc_phase;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      en_ff   <= '0;
      duty_ff <= '0;
      pwm_ff  <= '0;
      chop_ff <= 1'b0;
      cur_ff  <= '0;
      idx_ff  <= 2'h0;
      cv_ff   <= 1'b0;
    end
    else
    begin
      en_ff   <= nxt_en;
      duty_ff <= nxt_duty;
      pwm_ff  <= nxt_pwm;
      chop_ff <= nxt_chop;
      cur_ff  <= nxt_cur;
      idx_ff  <= nxt_idx;
      cv_ff   <= nxt_cv;
    end
  end

  assign drive_en            = en_ff;
  assign brake_chop          = chop_ff;
  assign phase_current       = cur_ff;
  assign phase_current_idx   = idx_ff;
  assign phase_current_valid = cv_ff;
endmodule : bfp_bridge_fault_protection

// [bench/bfp_fp_chk.sv]
// port assertions for the bridge fault protection block
`timescale 1ns/1ns
module bfp_fp_chk
  import bfp_pkg::*;
(
  // clock and reset
  input wire logic                        sys_clk,
  input wire logic                        srst,
  // inputs watched
  input wire logic                        temp_pw_pin,
  input wire logic                        cfg_wr,
  input wire logic [BFP_CFG_W-1:0]        cfg_wdata,
  input wire logic                        status_clr,
  input wire logic [BFP_PHASES-1:0]       drive_req,
  input wire logic [BFP_ADC_W-1:0]        adc_code,
  input wire logic                        adc_valid,
  // outputs watched
  input wire logic [BFP_CFG_W-1:0]        cfg_rdata,
  input wire logic                        prewarn_flag,
  input wire logic                        overtemp_shutdown_flag,
  input wire logic                        motor_latched_off,
  input wire logic [BFP_PHASES-1:0]       drive_en,
  input wire logic signed [BFP_ADC_W-1:0] phase_current,
  input wire logic                        phase_current_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // two sync stages plus the flag register
  property p_prewarn; temp_pw_pin |-> ##3 prewarn_flag; endproperty
  a_prewarn: assert property (p_prewarn) else $error("prewarn late");
  property p_ot_off; $rose(overtemp_shutdown_flag) |-> ##[0:1] drive_en == '0; endproperty
  a_ot_off: assert property (p_ot_off) else $error("drive not off");
  property p_cfg_wr; cfg_wr && cfg_wdata[21:20] != 2'h0 |=> cfg_rdata == $past(cfg_wdata);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config not stored");
  property p_cfg_r0; cfg_wr && cfg_wdata[21:20] == 2'h0 |=> cfg_rdata[21:20] == BFP_RETRY_MIN;
  endproperty
  a_cfg_r0: assert property (p_cfg_r0) else $error("retry zero kept");
  property p_cfg_hold; !cfg_wr |=> $stable(cfg_rdata); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config drifted");
  property p_flag_hold; prewarn_flag && !status_clr |=> prewarn_flag; endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  property p_latch; motor_latched_off && !status_clr |=> motor_latched_off && drive_en == '0;
  endproperty
  a_latch: assert property (p_latch) else $error("latch lost");
  property p_drive; drive_en != '0 |-> (drive_en & ~$past(drive_req)) == '0; endproperty
  a_drive: assert property (p_drive) else $error("drive without request");
  property p_adc;
    adc_valid |=> phase_current_valid && phase_current == $signed($past(adc_code) - BFP_ADC_MID);
  endproperty
  a_adc: assert property (p_adc) else $error("current wrong");
  property p_adc_v; !adc_valid |=> !phase_current_valid; endproperty
  a_adc_v: assert property (p_adc_v) else $error("stray current valid");
endmodule : bfp_fp_chk

// [bench/bfp_bridge_model.sv]
// behavioural gate drive stage and bridge comparators
`timescale 1ns/1ns
module bfp_bridge_model
  import bfp_pkg::*;
(
  // clock and drive
  input wire logic                        sys_clk,
  input wire logic [BFP_PHASES-1:0]       drive_en,
  // injected shorts
  input wire logic [BFP_PHASES-1:0]       inj_hs,
  input wire logic [BFP_PHASES-1:0]       inj_ls,
  // comparator side
  output logic [BFP_PHASES-1:0]           sw_event_pin,
  output logic [BFP_PHASES*BFP_LVL_W-1:0] hs_drop_pin,
  output logic [BFP_PHASES*BFP_LVL_W-1:0] ls_drop_pin
);
  logic [BFP_PHASES-1:0] en_d = '0;
  logic [BFP_PHASES-1:0] sw_q = '0;
  // the node slews one cycle after the gate changes
  always @(posedge sys_clk)
  begin
    en_d <= drive_en;
    sw_q <= drive_en ^ en_d;
  end
  assign sw_event_pin = sw_q;
  // a short only drops voltage on a conducting phase; idle codes differ per phase
  always_comb
  begin
    for (int p = 0; p < BFP_PHASES; p++)
    begin
      hs_drop_pin[4*p +: 4] = (inj_hs[p] & en_d[p]) ? 4'hc : 4'h1 + 4'(p);
      ls_drop_pin[4*p +: 4] = (inj_ls[p] & en_d[p]) ? 4'hc : 4'h2 - 4'(p);
    end
  end
endmodule : bfp_bridge_model

// [bench/tb_bridge_fault_protection.sv]
// self-checking bench for the bridge fault protection block
`timescale 1ns/1ns
module tb_bridge_fault_protection;
  import bfp_pkg::*;
  logic sys_clk, srst, cfg_wr, global_off, status_clr, temp_pw_pin, temp_136_pin;
  logic temp_143_pin, temp_150_pin, overshoot_pin, adc_valid, prewarn_flag;
  logic overtemp_shutdown_flag, motor_latched_off, brake_chop, phase_current_valid;
  logic [1:0] ot_level_sel, adc_phase, phase_current_idx;
  logic [2:0] sw_event_pin, hs_short_flag, ls_short_flag, drive_req, drive_en, inj_hs, inj_ls;
  logic [11:0] hs_drop_pin, ls_drop_pin, adc_code;
  logic [13:0] adc_exp, exp_q[$];
  logic [23:0] cfg_wdata, cfg_rdata;
  logic signed [11:0] phase_current;
  logic [31:0] rng;
  int err_count, checks, i, n;
  initial
  begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  bfp_bridge_fault_protection uut (.sys_clk(sys_clk), .srst(srst), .temp_pw_pin(temp_pw_pin),
    .temp_136_pin(temp_136_pin), .temp_143_pin(temp_143_pin), .temp_150_pin(temp_150_pin),
    .ot_level_sel(ot_level_sel), .sw_event_pin(sw_event_pin), .hs_drop_pin(hs_drop_pin),
    .ls_drop_pin(ls_drop_pin), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .global_off(global_off),
    .cfg_rdata(cfg_rdata), .status_clr(status_clr), .prewarn_flag(prewarn_flag),
    .overtemp_shutdown_flag(overtemp_shutdown_flag), .hs_short_flag(hs_short_flag),
    .ls_short_flag(ls_short_flag), .motor_latched_off(motor_latched_off),
    .drive_req(drive_req), .drive_en(drive_en), .overshoot_pin(overshoot_pin),
    .brake_chop(brake_chop), .adc_code(adc_code), .adc_phase(adc_phase),
    .adc_valid(adc_valid), .phase_current(phase_current),
    .phase_current_idx(phase_current_idx), .phase_current_valid(phase_current_valid));
  bfp_bridge_model u_model (.sys_clk(sys_clk), .drive_en(drive_en), .inj_hs(inj_hs),
    .inj_ls(inj_ls), .sw_event_pin(sw_event_pin), .hs_drop_pin(hs_drop_pin),
    .ls_drop_pin(ls_drop_pin));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xorshift = v ^ (v << 5);
  endfunction : xorshift
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic cfg(input logic [23:0] v);
    @(posedge sys_clk) cfg_wr <= 1'b1;
    cfg_wdata <= v;
    @(posedge sys_clk) cfg_wr <= 1'b0;
    tick(1);
  endtask : cfg
  task automatic clr;
    @(posedge sys_clk) status_clr <= 1'b1;
    @(posedge sys_clk) status_clr <= 1'b0;
    tick(2);
  endtask : clr
  task report_and_stop;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // result monitor: an empty queue yields x so a stray result never matches
  // sampled mid-cycle so the registered outputs have settled
  always @(negedge sys_clk)
  begin
    if (phase_current_valid === 1'b1)
    begin
      adc_exp = exp_q.size() ? exp_q.pop_front() : 14'hxxxx;
      chk({10'h0, phase_current_idx, phase_current}, {10'h0, adc_exp});
    end
  end
  initial
  begin
    #50000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    {srst, cfg_wr, cfg_wdata, global_off, status_clr, overshoot_pin} = {1'b1, 28'h0};
    {temp_pw_pin, temp_136_pin, temp_143_pin, temp_150_pin, ot_level_sel} = 6'h01;
    {drive_req, inj_hs, inj_ls, adc_code, adc_phase, adc_valid} = '0;
    rng = 32'hcaba218c;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    tick(1);
    chk(cfg_rdata, BFP_CFG_RESET);
    chk({prewarn_flag, overtemp_shutdown_flag, hs_short_flag, ls_short_flag}, 0);
    cfg(24'h0c0f88);
    chk(cfg_rdata, 24'h1c0f88);
    cfg(24'h204288);
    chk(cfg_rdata, 24'h204288);
    @(posedge sys_clk) drive_req <= 3'h7;
    @(posedge sys_clk) temp_pw_pin <= 1'b1;
    temp_136_pin <= 1'b1;
    tick(5);
    chk(prewarn_flag, 1);
    chk(overtemp_shutdown_flag, 0);
    @(posedge sys_clk) temp_143_pin <= 1'b1;
    tick(5);
    chk({overtemp_shutdown_flag, drive_en}, 4'h8);
    @(posedge sys_clk) {temp_136_pin, temp_143_pin} <= 2'b00;
    tick(8);
    chk(drive_en, 0);
    @(posedge sys_clk) temp_pw_pin <= 1'b0;
    tick(6);
    chk(drive_en, 3'h7);
    clr();
    chk(overtemp_shutdown_flag, 0);
    @(posedge sys_clk) inj_ls <= 3'h1;
    for (i = 0; i < 60 && ls_short_flag[0] !== 1'b1; i++) tick(1);
    chk({ls_short_flag, drive_en, motor_latched_off}, 7'h1c);
    // retry count two: two re-arms survive, the third short latches off
    repeat (2)
    begin
      @(posedge sys_clk) drive_req <= 3'h6;
      tick(3);
      @(posedge sys_clk) drive_req <= 3'h7;
      tick(20);
    end
    for (i = 0; i < 60 && motor_latched_off !== 1'b1; i++) tick(1);
    tick(1);
    chk({motor_latched_off, drive_en}, 4'h8);
    @(posedge sys_clk) {inj_ls, drive_req} <= 6'h0;
    clr();
    chk(motor_latched_off, 0);
    // glitch within the blanking window right after switching on
    @(posedge sys_clk) {drive_req, inj_ls} <= 6'h3a;
    tick(3);
    @(posedge sys_clk) inj_ls <= 3'h0;
    tick(6);
    chk(ls_short_flag, 0);
    @(posedge sys_clk) inj_hs <= 3'h4;
    @(posedge sys_clk) inj_hs <= 3'h0;
    tick(6);
    chk(hs_short_flag, 0);
    @(posedge sys_clk) {global_off, inj_hs} <= 4'hc;
    for (i = 0; i < 60 && hs_short_flag[2] !== 1'b1; i++) tick(1);
    tick(1);
    chk({hs_short_flag, drive_en}, 6'h20);
    @(posedge sys_clk) {inj_hs, drive_req} <= 6'h0;
    clr();
    cfg(24'he04288);
    @(posedge sys_clk) drive_req <= 3'h7;
    tick(8);
    @(posedge sys_clk) {inj_hs, inj_ls} <= 6'h11;
    tick(12);
    chk({hs_short_flag, ls_short_flag, drive_en}, 9'h08f);
    @(posedge sys_clk) {inj_hs, inj_ls} <= 6'h0;
    for (i = 0; i < 24; i++)
    begin
      rng = xorshift(rng);
      @(posedge sys_clk) {adc_phase, adc_code} <= rng[13:0];
      adc_valid <= 1'b1;
      overshoot_pin <= rng[20];
      exp_q.push_back({rng[13:12], rng[11:0] - BFP_ADC_MID});
    end
    @(posedge sys_clk) adc_valid <= 1'b0;
    tick(3);
    chk(24'(exp_q.size()), 24'h0);
    @(posedge sys_clk) overshoot_pin <= 1'b1;
    n = 0;
    repeat (300)
    begin
      tick(1);
      n += (brake_chop === 1'b1);
    end
    chk(n > 0, 1);
    // highest shutdown level selected and reached
    @(posedge sys_clk) {ot_level_sel, temp_150_pin} <= 3'h5;
    tick(5);
    chk({overtemp_shutdown_flag, drive_en}, 4'h8);
    report_and_stop();
  end
endmodule : tb_bridge_fault_protection
bind bfp_bridge_fault_protection bfp_fp_chk u_chk (.sys_clk(sys_clk), .srst(srst),
  .temp_pw_pin(temp_pw_pin), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
  .status_clr(status_clr), .drive_req(drive_req), .adc_code(adc_code),
  .adc_valid(adc_valid), .cfg_rdata(cfg_rdata), .prewarn_flag(prewarn_flag),
  .overtemp_shutdown_flag(overtemp_shutdown_flag), .motor_latched_off(motor_latched_off),
  .drive_en(drive_en), .phase_current(phase_current),
  .phase_current_valid(phase_current_valid));
